// File: bus_line_monitor.sv
// line monitor: synchronises clock and data lines, finds start and stop
// assumes the lines arrive asynchronously from the bus pins
`timescale 1ns/1ps
module bus_line_monitor (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // raw line levels
  input  wire logic scl_i,
  input  wire logic sda_i,
  // synchronised clock level and events
  output logic      scl_o,
  output logic      start_o,
  output logic      stop_o
);

  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic       sda_prev;
  logic       scl_prev;

  // two-stage synchronisers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
    end else begin
      scl_sync <= {scl_sync[0], scl_i};
      sda_sync <= {sda_sync[0], sda_i};
    end
  end

  // edge history of the synchronised lines
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sda_prev <= 1'b1;
      scl_prev <= 1'b1;
    end else begin
      sda_prev <= sda_sync[1];
      scl_prev <= scl_sync[1];
    end
  end

  assign scl_o = scl_prev;

  // condition events
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_o <= 1'b0;
      stop_o  <= 1'b0;
    end else begin
      start_o <= sda_prev & ~sda_sync[1] & scl_prev & scl_sync[1];
      stop_o  <= ~sda_prev & sda_sync[1] & scl_prev & scl_sync[1];
    end
  end

endmodule // bus_line_monitor

// File: bus_peer.sv
// partner model: other devices on the two-wire bus, lines with pull-ups
// assumes the design drives its pins open-drain, enable low while pulling
`timescale 1ns/1ps
module bus_peer #(
  parameter int HALF_NS = 80
) (
  // design pin drive
  input  wire logic scl_drv_i,
  input  wire logic scl_oe_n_i,
  input  wire logic sda_drv_i,
  input  wire logic sda_oe_n_i,
  // resolved line levels
  output logic      scl_o,
  output logic      sda_o
);
  logic peer_scl;
  logic peer_sda;

  initial begin
    peer_scl = 1'b1;
    peer_sda = 1'b1;
  end

  // wired-and, released lines pulled high
  assign scl_o = peer_scl & (scl_oe_n_i | scl_drv_i);
  assign sda_o = peer_sda & (sda_oe_n_i | sda_drv_i);

  task automatic make_start();
    peer_sda = 1'b0;
    #(HALF_NS);
    peer_scl = 1'b0;
    #(HALF_NS);
  endtask

  task automatic make_stop();
    peer_sda = 1'b0;
    #(HALF_NS);
    peer_scl = 1'b1;
    #(HALF_NS);
    peer_sda = 1'b1;
    #(HALF_NS);
  endtask
endmodule // bus_peer

// File: i2c_control_flags.sv
// control and flag logic of the two-wire bus interface, wishbone slave
// assumes the shift engine and transfer controller run on clk_i
`timescale 1ns/1ps
`include "i2c_ctrl_regs.svh"
module i2c_control_flags #(
  parameter int COND_HOLD_CYCLES = `COND_CYC
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // bus pins
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_n_o,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n_o,
  // shift engine events
  input  wire logic        xfer_active_i,
  input  wire logic        xfer_done_i,
  input  wire logic        ack_bit_i,
  input  wire logic        arb_lost_i,
  input  wire logic        addr_match_i,
  input  wire logic        first_frame_i,
  input  wire logic        rw_bit_i,
  // transfer controller
  output logic             tctl_start_o,
  input  wire logic        tctl_done_i,
  input  wire logic        tctl_access_i,
  // mode and interrupt
  output logic             master_o,
  output logic             transmit_o,
  output logic             irq_o
);
  import i2c_ctrl_pkg::*;

  generate
    if (COND_HOLD_CYCLES < 1 || COND_HOLD_CYCLES > 65535) begin : g_bad
      $error("COND_HOLD_CYCLES out of range");
    end
  endgenerate

  localparam logic [15:0] HOLD = 16'(COND_HOLD_CYCLES);

  logic        enable;
  logic        ien;
  logic        master_select;
  logic        transmit_select;
  logic        ack_check_enable;
  logic        bus_busy_flag;
  logic        interrupt_request_flag;
  logic        transfer_request_flag;
  logic        transmit_empty_flag;
  logic        receive_full_flag;
  logic        received_ack_flag;
  logic        format_switch_bit;
  logic        fmt_prev;
  logic        trs_lock;
  logic        trs_seen;
  logic        trs_pend;
  logic        trs_pend_val;
  logic        interrupt_request_flag_seen;
  logic        scl_sync;
  logic        start_det;
  logic        stop_det;
  logic        cond_stop;
  logic [15:0] cond_cnt;
  cond_state_e cond_state;

  // bus access decode
  logic wr_fire;
  logic rd_fire;
  logic ctrl_wr;
  logic ctrl_rd;
  logic fmt_wr;
  reg_byte_t wbyte;

  function automatic logic hit(input logic [3:0] adr, input logic [3:0] base);
    return adr == base;
  endfunction

  assign wr_fire = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
  assign rd_fire = wb_cyc_i & wb_stb_i & wb_ack_o & ~wb_we_i;
  assign ctrl_wr = wr_fire & hit(wb_adr_i, `CTRL_ADDR);
  assign ctrl_rd = rd_fire & hit(wb_adr_i, `CTRL_ADDR);
  assign fmt_wr  = wr_fire & hit(wb_adr_i, `FMT_ADDR);
  assign wbyte   = wb_dat_i[7:0];

  // engine events
  logic hw_force_rx;
  logic hw_force_tx;
  logic tx_end;
  logic nack_end;
  logic fmt_fall;
  logic trs_wr_ok;

  assign fmt_fall    = fmt_prev & ~format_switch_bit;
  assign hw_force_rx = (arb_lost_i & master_select) | fmt_fall;
  assign hw_force_tx = first_frame_i & ~master_select & rw_bit_i;
  assign tx_end      = xfer_done_i & transmit_select;
  assign nack_end    = tx_end & ack_check_enable & ack_bit_i;
  assign trs_wr_ok   = ~trs_lock | trs_seen;

  bus_line_monitor u_mon (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .scl_i   (scl_i),
    .sda_i   (sda_i),
    .scl_o   (scl_sync),
    .start_o (start_det),
    .stop_o  (stop_det)
  );

  // wishbone answer, one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_dat_o <= 32'h0;
      if (wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_we_i) begin
        if (hit(wb_adr_i, `CTRL_ADDR)) begin
          wb_dat_o[7:0] <= {enable, ien, master_select, transmit_select,
                            ack_check_enable, bus_busy_flag,
                            interrupt_request_flag, 1'b1};
        end else if (hit(wb_adr_i, `STAT_ADDR)) begin
          wb_dat_o[3:0] <= {receive_full_flag, transmit_empty_flag,
                            transfer_request_flag, received_ack_flag};
        end else if (hit(wb_adr_i, `FMT_ADDR)) begin
          wb_dat_o[0] <= format_switch_bit;
        end
      end
    end
  end

  // plain control bits and format switch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable            <= 1'b0;
      ien               <= 1'b0;
      ack_check_enable  <= 1'b0;
      format_switch_bit <= 1'b0;
      fmt_prev          <= 1'b0;
    end else begin
      fmt_prev <= format_switch_bit;
      if (ctrl_wr) begin
        enable           <= wbyte[`CTRL_ENABLE];
        ien              <= wbyte[`CTRL_IEN];
        ack_check_enable <= wbyte[`CTRL_ACK_CHECK_ENABLE];
      end
      if (fmt_wr) begin
        format_switch_bit <= wbyte[`FMT_SWITCH];
      end
    end
  end

  // master select, cleared on arbitration loss
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      master_select <= 1'b0;
    end else if (arb_lost_i & master_select) begin
      master_select <= 1'b0;
    end else if (ctrl_wr) begin
      master_select <= wbyte[`CTRL_MST];
    end
  end

  // transmit select with hardware overrides and deferral
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      transmit_select <= 1'b0;
      trs_pend        <= 1'b0;
      trs_pend_val    <= 1'b0;
    end else if (hw_force_rx) begin
      transmit_select <= 1'b0;
      trs_pend        <= 1'b0;
    end else if (hw_force_tx) begin
      transmit_select <= 1'b1;
      trs_pend        <= 1'b0;
    end else if (ctrl_wr & (trs_wr_ok | wbyte[`CTRL_TRS] == transmit_select)) begin
      if (xfer_active_i & ~xfer_done_i) begin
        trs_pend     <= 1'b1;
        trs_pend_val <= wbyte[`CTRL_TRS];
      end else begin
        transmit_select <= wbyte[`CTRL_TRS];
        trs_pend        <= 1'b0;
      end
    end else if (trs_pend & xfer_done_i) begin
      transmit_select <= trs_pend_val;
      trs_pend        <= 1'b0;
    end
  end

  // read-before-write lock on transmit select
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trs_lock <= 1'b0;
      trs_seen <= 1'b0;
    end else if (hw_force_rx | hw_force_tx) begin
      trs_lock <= 1'b1;
      trs_seen <= 1'b0;
    end else if (ctrl_wr & trs_wr_ok) begin
      trs_lock <= 1'b0;
      trs_seen <= 1'b0;
    end else if (ctrl_rd & trs_lock & wb_dat_o[`CTRL_TRS] == transmit_select) begin
      // read of the forced value unlocks
      trs_seen <= 1'b1;
    end
  end

  // bus busy from line conditions
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_busy_flag <= 1'b0;
    end else if (start_det) begin
      bus_busy_flag <= 1'b1;
    end else if (stop_det) begin
      bus_busy_flag <= 1'b0;
    end
  end

  // start and stop generation
  always_ff @(posedge clk_i) begin
    if (rst_i | ~enable) begin
      cond_state <= COND_IDLE;
      cond_stop  <= 1'b0;
      cond_cnt   <= 16'h0;
      scl_oe_n_o <= 1'b1;
      sda_oe_n_o <= 1'b1;
    end else begin
      case (cond_state)
        COND_IDLE: begin
          // request only in master mode, prohibit zero
          if (ctrl_wr & master_select & ~wbyte[`CTRL_PROHIBIT]) begin
            cond_stop  <= ~wbyte[`CTRL_BUS_BUSY_FLAG];
            sda_oe_n_o <= wbyte[`CTRL_BUS_BUSY_FLAG];
            scl_oe_n_o <= 1'b1;
            cond_cnt   <= HOLD;
            cond_state <= COND_PREP;
          end
        end
        COND_PREP: begin
          if (cond_cnt != 16'h0) begin
            cond_cnt <= cond_cnt - 16'h1;
          end else if (scl_sync) begin
            sda_oe_n_o <= cond_stop;
            cond_cnt   <= HOLD;
            cond_state <= COND_EDGE;
          end
        end
        COND_EDGE: begin
          if (cond_cnt != 16'h0) begin
            cond_cnt <= cond_cnt - 16'h1;
          end else begin
            scl_oe_n_o <= cond_stop;
            cond_state <= COND_IDLE;
          end
        end
        default: begin
          cond_state <= COND_IDLE;
        end
      endcase
    end
  end

  // received ack flag
  always_ff @(posedge clk_i) begin
    if (rst_i | ~ack_check_enable) begin
      received_ack_flag <= 1'b0;
    end else if (tx_end) begin
      received_ack_flag <= ack_bit_i;
    end
  end

  // transfer flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      transmit_empty_flag   <= 1'b0;
      receive_full_flag     <= 1'b0;
      transfer_request_flag <= 1'b0;
    end else begin
      if (tx_end & ~nack_end) begin
        transmit_empty_flag   <= 1'b1;
        transfer_request_flag <= 1'b1;
      end else if (xfer_done_i & ~transmit_select) begin
        receive_full_flag     <= 1'b1;
        transfer_request_flag <= 1'b1;
      end else if (tctl_done_i) begin
        transmit_empty_flag   <= 1'b0;
        receive_full_flag     <= 1'b0;
        transfer_request_flag <= 1'b0;
      end else if (tctl_access_i) begin
        transmit_empty_flag   <= 1'b0;
        receive_full_flag     <= 1'b0;
      end
    end
  end

  // interrupt request flag, set wins over clear
  logic interrupt_request_flag_set;
  assign interrupt_request_flag_set = xfer_done_i | stop_det |
                    (addr_match_i & ~master_select & ~transmit_select) |
                    (arb_lost_i & master_select & transmit_select);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      interrupt_request_flag <= 1'b0;
      interrupt_request_flag_seen              <= 1'b0;
    end else if (interrupt_request_flag_set) begin
      interrupt_request_flag <= 1'b1;
    end else if (ctrl_wr & ~wbyte[`CTRL_INTERRUPT_REQUEST_FLAG] & interrupt_request_flag_seen) begin
      interrupt_request_flag <= 1'b0;
      interrupt_request_flag_seen              <= 1'b0;
    end else if (tctl_done_i | (tctl_access_i & transfer_request_flag)) begin
      interrupt_request_flag <= 1'b0;
      interrupt_request_flag_seen              <= 1'b0;
    end else if (ctrl_rd & wb_dat_o[`CTRL_INTERRUPT_REQUEST_FLAG]) begin
      interrupt_request_flag_seen <= 1'b1;
    end
  end

  // registered outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o      <= 1'b0;
      master_o   <= 1'b0;
      transmit_o <= 1'b0;
      scl_o      <= 1'b0;
      sda_o      <= 1'b0;
    end else begin
      irq_o      <= interrupt_request_flag & ien;
      master_o   <= master_select;
      transmit_o <= transmit_select;
      scl_o      <= 1'b0;
      sda_o      <= 1'b0;
    end
  end

  assign tctl_start_o = transfer_request_flag;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  arb_clears_trs_a: assert property (arb_lost_i && master_select |=> !transmit_select)
    else $error("arbitration loss kept transmit mode");
  fmt_fall_trs_a: assert property ($fell(format_switch_bit) |-> ##1 !transmit_select)
    else $error("format switch fall kept transmit mode");
  slave_read_a: assert property (hw_force_tx && !hw_force_rx |=> transmit_select)
    else $error("slave read did not select transmit");
  ack_hidden_a: assert property (!ack_check_enable |=> !received_ack_flag)
    else $error("ack flag shown while checking off");
  nack_stops_a: assert property (nack_end && !transfer_request_flag |=>
                                 !transfer_request_flag && interrupt_request_flag)
    else $error("refused ack started controller");
  ack_sets_a: assert property (tx_end && !nack_end && !tctl_done_i |=>
                               transmit_empty_flag && transfer_request_flag
                               && interrupt_request_flag)
    else $error("accepted transmit end missed a flag");
  busy_track_a: assert property (start_det |=> bus_busy_flag)
    else $error("start did not set bus busy");
  stop_free_a: assert property (stop_det && !start_det |=> !bus_busy_flag)
    else $error("stop did not clear bus busy");
  slave_no_cond_a: assert property (ctrl_wr && !master_select && cond_state == COND_IDLE
                                    |=> cond_state == COND_IDLE)
    else $error("slave write issued a condition");
  interrupt_request_flag_clear_a: assert property ($fell(interrupt_request_flag) |->
                                 $past(interrupt_request_flag_seen) || $past(tctl_done_i)
                                 || $past(tctl_access_i))
    else $error("interrupt flag cleared without cause");
  irq_gate_a: assert property (interrupt_request_flag && ien |=> ##[0:1] irq_o)
    else $error("interrupt output missing");

endmodule // i2c_control_flags

// File: i2c_ctrl_pkg.sv
// shared types of the two-wire control block
// assumes the constants header is included by the design files
package i2c_ctrl_pkg;

  // start or stop generation sequence
  typedef enum logic [1:0] {
    COND_IDLE = 2'b00,
    COND_PREP = 2'b01,
    COND_EDGE = 2'b10
  } cond_state_e;

  typedef logic [7:0] reg_byte_t;

endpackage

// File: i2c_ctrl_regs.svh
// register offsets, field positions, reset values and timing counts
// assumes a 100 MHz system clock and a 32-bit classic wishbone slave port
`ifndef I2C_CTRL_REGS_SVH
`define I2C_CTRL_REGS_SVH

// byte addresses of the register words
`define CTRL_ADDR      4'h0
`define STAT_ADDR      4'h4
`define FMT_ADDR       4'h8

// control register fields
`define CTRL_ENABLE    7
`define CTRL_IEN       6
`define CTRL_MST       5
`define CTRL_TRS       4
`define CTRL_ACK_CHECK_ENABLE      3
`define CTRL_BUS_BUSY_FLAG      2
`define CTRL_INTERRUPT_REQUEST_FLAG      1
`define CTRL_PROHIBIT  0
`define CTRL_RESET     8'h01

// status register fields
`define STAT_RXACK     0
`define STAT_TREQ      1
`define STAT_TXEMPTY   2
`define STAT_RXFULL    3

// format switch register field
`define FMT_SWITCH     0

// timing
`define CLK_MHZ        100
`define T_COND_NS      5000
`define COND_CYC       ((`T_COND_NS * `CLK_MHZ + 999) / 1000)

`endif

// File: testbench.sv
// testbench: register and event tests of the two-wire control block
// assumes bus_peer stands on the lines and engine events are driven here
`timescale 1ns/1ps
`include "i2c_ctrl_regs.svh"
module testbench;
  import i2c_ctrl_pkg::*;
  logic        clk_i;
  logic        rst_i;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [3:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic        scl_line;
  logic        sda_line;
  logic        scl_drv;
  logic        scl_oe_n;
  logic        sda_drv;
  logic        sda_oe_n;
  logic        xfer_active;
  logic        ack_bit;
  logic        rw_bit;
  logic [5:0]  ev;
  logic        tctl_start;
  logic        master;
  logic        transmit;
  logic        irq;
  int          miscompares;
  int          n_checks;
  int          cycles;

  i2c_control_flags #(.COND_HOLD_CYCLES(4)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .scl_i(scl_line), .scl_o(scl_drv), .scl_oe_n_o(scl_oe_n),
    .sda_i(sda_line), .sda_o(sda_drv), .sda_oe_n_o(sda_oe_n),
    .xfer_active_i(xfer_active), .xfer_done_i(ev[0]), .ack_bit_i(ack_bit),
    .arb_lost_i(ev[1]), .addr_match_i(ev[2]), .first_frame_i(ev[3]),
    .rw_bit_i(rw_bit), .tctl_start_o(tctl_start), .tctl_done_i(ev[4]),
    .tctl_access_i(ev[5]), .master_o(master), .transmit_o(transmit),
    .irq_o(irq)
  );

  bus_peer i_peer (
    .scl_drv_i(scl_drv), .scl_oe_n_i(scl_oe_n),
    .sda_drv_i(sda_drv), .sda_oe_n_i(sda_oe_n),
    .scl_o(scl_line), .sda_o(sda_line)
  );

  always #5 clk_i = ~clk_i;

  task automatic stop_test();
    if (miscompares == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      stop_test();
    end
  end

  task automatic chk8(input reg_byte_t got, input reg_byte_t exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wb_cycle(input logic [3:0] a, input logic w, input reg_byte_t d,
                          output reg_byte_t r);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    r = rdat[7:0];
    chk1(ack, 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input reg_byte_t d);
    reg_byte_t r;
    wb_cycle(a, 1'b1, d, r);
  endtask

  task automatic rd(input logic [3:0] a, input reg_byte_t exp);
    reg_byte_t r;
    wb_cycle(a, 1'b0, 8'h00, r);
    chk8(r, exp);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic pulse(input logic [5:0] m);
    @(posedge clk_i);
    ev <= m;
    @(posedge clk_i);
    ev <= 6'h00;
    settle(3);
  endtask

  initial begin
    int n;
    clk_i = 1'b0;
    rst_i = 1'b1;
    {cyc, stb, we, xfer_active, ack_bit, rw_bit} = 6'h00;
    adr = 4'h0;
    sel = 4'h1;
    wdat = 32'h00000000;
    ev = 6'h00;
    miscompares = 0;
    n_checks = 0;
    cycles = 0;
    settle(6);
    rst_i <= 1'b0;
    rd(`CTRL_ADDR, 8'h01);
    rd(`STAT_ADDR, 8'h00);
    rd(`FMT_ADDR, 8'h00);
    rd(4'hc, 8'h00);
    chk1(sda_oe_n, 1'b1);
    // slave mode: start request dropped, prohibit not stored
    wr(`CTRL_ADDR, 8'h80);
    wr(`CTRL_ADDR, 8'h84);
    settle(20);
    chk1(sda_oe_n, 1'b1);
    rd(`CTRL_ADDR, 8'h81);
    // foreign start and stop on the lines
    i_peer.make_start();
    rd(`CTRL_ADDR, 8'h85);
    i_peer.make_stop();
    rd(`CTRL_ADDR, 8'h83);
    wr(`CTRL_ADDR, 8'h81);
    rd(`CTRL_ADDR, 8'h81);
    // own start and stop as master transmitter
    wr(`CTRL_ADDR, 8'hb1);
    settle(3);
    chk1(master, 1'b1);
    chk1(transmit, 1'b1);
    wr(`CTRL_ADDR, 8'hb6);
    n = 0;
    while (sda_oe_n !== 1'b0 && n < 60) begin
      @(posedge clk_i);
      n++;
    end
    chk1(sda_oe_n, 1'b0);
    chk1(scl_line, 1'b1);
    settle(30);
    chk1(scl_line, 1'b0);
    chk1(sda_line, 1'b0);
    rd(`CTRL_ADDR, 8'hb5);
    wr(`CTRL_ADDR, 8'hb2);
    settle(40);
    chk1(sda_line, 1'b1);
    chk1(scl_line, 1'b1);
    rd(`CTRL_ADDR, 8'hb3);
    wr(`CTRL_ADDR, 8'hb1);
    // ack checking off, refused ack still counts
    ack_bit <= 1'b1;
    pulse(6'h01);
    rd(`STAT_ADDR, 8'h06);
    chk1(tctl_start, 1'b1);
    rd(`CTRL_ADDR, 8'hb3);
    pulse(6'h10);
    rd(`STAT_ADDR, 8'h00);
    rd(`CTRL_ADDR, 8'hb1);
    ack_bit <= 1'b0;
    pulse(6'h01);
    pulse(6'h20);
    rd(`CTRL_ADDR, 8'hb1);
    pulse(6'h10);
    // ack checking on
    wr(`CTRL_ADDR, 8'hf9);
    ack_bit <= 1'b1;
    pulse(6'h01);
    rd(`STAT_ADDR, 8'h01);
    chk1(tctl_start, 1'b0);
    chk1(irq, 1'b1);
    wr(`CTRL_ADDR, 8'hf9);
    rd(`CTRL_ADDR, 8'hfb);
    wr(`CTRL_ADDR, 8'hf9);
    rd(`CTRL_ADDR, 8'hf9);
    chk1(irq, 1'b0);
    ack_bit <= 1'b0;
    pulse(6'h01);
    rd(`STAT_ADDR, 8'h06);
    chk1(tctl_start, 1'b1);
    pulse(6'h10);
    // arbitration loss and the transmit select lock
    wr(`CTRL_ADDR, 8'hb1);
    pulse(6'h02);
    chk1(master, 1'b0);
    chk1(transmit, 1'b0);
    wr(`CTRL_ADDR, 8'h93);
    rd(`CTRL_ADDR, 8'h83);
    wr(`CTRL_ADDR, 8'h91);
    rd(`CTRL_ADDR, 8'h91);
    chk1(transmit, 1'b1);
    // format switch falling
    wr(`FMT_ADDR, 8'h01);
    wr(`FMT_ADDR, 8'h00);
    settle(3);
    chk1(transmit, 1'b0);
    rd(`CTRL_ADDR, 8'h81);
    wr(`CTRL_ADDR, 8'h81);
    // slave addressed for read, deferred change
    pulse(6'h04);
    rd(`CTRL_ADDR, 8'h83);
    wr(`CTRL_ADDR, 8'h81);
    rw_bit <= 1'b1;
    pulse(6'h08);
    chk1(transmit, 1'b1);
    wr(`CTRL_ADDR, 8'h83);
    settle(3);
    chk1(transmit, 1'b1);
    rd(`CTRL_ADDR, 8'h91);
    xfer_active <= 1'b1;
    wr(`CTRL_ADDR, 8'h83);
    settle(3);
    chk1(transmit, 1'b1);
    pulse(6'h01);
    xfer_active <= 1'b0;
    settle(2);
    chk1(transmit, 1'b0);
    stop_test();
  end
endmodule // testbench
